// File: rtl/adc_calibration_config_status.sv
// calibration configuration and status register bank with apb slave and interrupt
// What the document asks of this block and of its software
// RULE_01 - select 0: offset calibrates toward mid-code
// RULE_02 - select 1: offset matches spare converter reference
// RULE_03 - software sets select 1 only with background
// RULE_04 - three-bit offset averaging, reset six
// RULE_05 - three-bit linearity averaging low bits, reset one
// RULE_06 - status register read-only, holds three-bit code
// RULE_07 - halted flag set when background stops
// RULE_08 - halted flag clears when calibration resumes
// RULE_09 - background off: halted set on foreground end
// RULE_10 - foreground complete flag set when done or skipped
// RULE_11 - software writes reserved fields with reset values
// RULE_12 - foreground enable: clear values, run or skip
// RULE_13 - pin select: complete, halted, alarm, low
// RULE_14 - trigger source: software bit or pin
// RULE_15 - writes to status register are ignored
`timescale 1ns/1ps
module adc_calibration_config_status
   import cal_regs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trigger_input_pin,
   input wire cal_regs_pkg::engine_report_t engine_report,
   output cal_regs_pkg::engine_control_t engine_control,
   output logic status_output_pin,
   output logic irq
);
   import cal_regs_pkg::*;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_CLEAR, SEQ_RUN} seq_state_t;

   logic [7:0] offset_reference_config_ff;
   logic [7:0] calibration_averaging_ff;
   logic [7:0] calibration_pin_setup_ff;
   logic [7:0] calibration_control_ff;
   logic [EVENT_COUNT-1:0] event_status_ff;
   logic [EVENT_COUNT-1:0] event_mask_ff;
   logic foreground_complete_flag_ff;
   logic background_halted_ff;
   logic [2:0] status_code_ff;
   logic alarm_ff;
   logic [EVENT_COUNT-1:0] event_level_ff;
   logic start_ff;
   seq_state_t seq_ff;
   seq_state_t nxt_seq;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   engine_control_t control_ff;
   logic status_pin_ff;
   logic irq_ff;

   function automatic logic idx_hit(input logic [11:0] addr, input logic [7:0] idx);
      idx_hit = (addr[11:2] == {2'h0, idx}) && (addr[1:0] == 2'h0);
   endfunction

   // bus decode, no wait states, ready in the first access cycle
   wire setup_phase = psel && !penable && !pready_ff;
   wire access_done = psel && penable && pready_ff;
   wire hit_ref = idx_hit(paddr, IDX_OFFSET_REFERENCE_CONFIG);
   wire hit_avg = idx_hit(paddr, IDX_CALIBRATION_AVERAGING);
   wire hit_prog = idx_hit(paddr, IDX_CALIBRATION_PROGRESS);
   wire hit_pin = idx_hit(paddr, IDX_CALIBRATION_PIN_SETUP);
   wire hit_ctl = idx_hit(paddr, IDX_CALIBRATION_CONTROL);
   wire hit_evt = idx_hit(paddr, IDX_EVENT_STATUS);
   wire hit_msk = idx_hit(paddr, IDX_EVENT_MASK);
   wire hit_any = hit_ref || hit_avg || hit_prog || hit_pin || hit_ctl || hit_evt || hit_msk;
   wire wr_lane0 = access_done && pwrite && pstrb[0];
   // status register has no write path at all
   wire wr_ref = wr_lane0 && hit_ref;
   wire wr_avg = wr_lane0 && hit_avg;
   wire wr_pin = wr_lane0 && hit_pin;
   wire wr_ctl = wr_lane0 && hit_ctl; // RULE_15
   wire wr_msk = wr_lane0 && hit_msk;
   wire rd_evt = access_done && !pwrite && hit_evt;

   wire fg_enable = calibration_control_ff[FOREGROUND_ENABLE_BIT];
   wire bg_enable = calibration_control_ff[BACKGROUND_ENABLE_BIT];
   wire soft_trigger = calibration_control_ff[SOFTWARE_TRIGGER_BIT];
   wire [1:0] pin_select = calibration_pin_setup_ff[STATUS_PIN_SELECT_LSB +: 2];
   wire trigger_source = calibration_pin_setup_ff[TRIGGER_SOURCE_SELECT_BIT];

   wire [7:0] progress_byte = {3'h0, status_code_ff, background_halted_ff,
      foreground_complete_flag_ff}; // RULE_06
   wire [7:0] read_byte =
      hit_ref ? offset_reference_config_ff :
      hit_avg ? calibration_averaging_ff :
      hit_prog ? progress_byte :
      hit_pin ? calibration_pin_setup_ff :
      hit_ctl ? calibration_control_ff :
      hit_evt ? {5'h0, event_status_ff} :
      hit_msk ? {5'h0, event_mask_ff} : 8'h00;

   // foreground sequence: clear stored values, then run or skip
   wire seq_finish_run = (seq_ff == SEQ_RUN) && engine_report.foreground_complete_flag && !start_ff;
   wire seq_skip = (seq_ff == SEQ_CLEAR) && !fg_enable;
   wire fg_finished = seq_finish_run || seq_skip; // RULE_12

   always_comb
   begin
      nxt_seq = seq_ff;
      case (seq_ff)
         SEQ_IDLE:
         begin
            if (start_ff)
               nxt_seq = SEQ_CLEAR;
         end
         SEQ_CLEAR:
         begin
            nxt_seq = fg_enable ? SEQ_RUN : SEQ_IDLE; // RULE_12
         end
         // a control write aborts a running foreground pass and starts over
         SEQ_RUN:
         begin
            if (start_ff)
               nxt_seq = SEQ_CLEAR;
            else if (engine_report.foreground_complete_flag)
               nxt_seq = SEQ_IDLE;
         end
         default:
         begin
            nxt_seq = SEQ_IDLE;
         end
      endcase
   end

   // halted flag: stop wins over resume in the same cycle
   wire halt_set = bg_enable ? engine_report.bg_stopped : fg_finished; // RULE_07 RULE_09
   wire halt_clear = engine_report.bg_running; // RULE_08
   wire nxt_halted = halt_set || (background_halted_ff && !halt_clear);
   wire nxt_fg_complete = fg_finished || (foreground_complete_flag_ff && !start_ff); // RULE_10
   wire [EVENT_COUNT-1:0] nxt_level = {alarm_ff, background_halted_ff,
      foreground_complete_flag_ff};
   wire [EVENT_COUNT-1:0] nxt_event_status;

   // a read clears only what it returned, so a rise during the access is kept
   generate
      for (genvar gi = 0; gi < EVENT_COUNT; gi++)
      begin : g_event
         wire rise = nxt_level[gi] && !event_level_ff[gi];
         wire taken = rd_evt && prdata_ff[gi];
         assign nxt_event_status[gi] = rise || (event_status_ff[gi] && !taken);
      end
   endgenerate

   wire nxt_status_pin =
      (pin_select == PIN_SEL_FOREGROUND) ? foreground_complete_flag_ff :
      (pin_select == PIN_SEL_BACKGROUND) ? background_halted_ff :
      (pin_select == PIN_SEL_ALARM) ? alarm_ff : 1'b0; // RULE_13
   wire nxt_trigger = trigger_source ? trigger_input_pin : soft_trigger; // RULE_14

   engine_control_t nxt_control;
   always_comb
   begin
      nxt_control.clear_values = (nxt_seq == SEQ_CLEAR);
      nxt_control.fg_run = (nxt_seq == SEQ_RUN);
      nxt_control.foreground_enable = fg_enable;
      nxt_control.background_enable = bg_enable;
      // 0 targets mid-code, 1 takes the spare converter as reference
      nxt_control.offset_reference_select =
         offset_reference_config_ff[OFFSET_REFERENCE_SELECT_BIT]; // RULE_01 RULE_02
      nxt_control.offset_average_depth =
         calibration_averaging_ff[OFFSET_AVERAGE_DEPTH_LSB +: AVERAGE_DEPTH_WIDTH]; // RULE_04
      nxt_control.linearity_average_depth =
         calibration_averaging_ff[LINEARITY_AVERAGE_DEPTH_LSB +: AVERAGE_DEPTH_WIDTH]; // RULE_05
      nxt_control.cal_trigger = nxt_trigger;
   end

   // reserved bits are stored as written, except in the event mask; software keeps them at reset values
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         offset_reference_config_ff <= RST_OFFSET_REFERENCE_CONFIG;
      else if (wr_ref)
         offset_reference_config_ff <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         calibration_averaging_ff <= RST_CALIBRATION_AVERAGING;
      else if (wr_avg)
         calibration_averaging_ff <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         calibration_pin_setup_ff <= RST_CALIBRATION_PIN_SETUP;
      else if (wr_pin)
         calibration_pin_setup_ff <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         calibration_control_ff <= RST_CALIBRATION_CONTROL;
      else if (wr_ctl)
         calibration_control_ff <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         event_mask_ff <= RST_EVENT_MASK;
      else if (wr_msk)
         event_mask_ff <= pwdata[EVENT_COUNT-1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         foreground_complete_flag_ff <= 1'b0;
      else
         foreground_complete_flag_ff <= nxt_fg_complete;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         background_halted_ff <= 1'b0;
      else
         background_halted_ff <= nxt_halted;
   end

   // code follows the engine one cycle late
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status_code_ff <= 3'h0;
      else
         status_code_ff <= engine_report.code; // RULE_06
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         alarm_ff <= 1'b0;
      else
         alarm_ff <= engine_report.alarm;
   end

   // edge history for the event flags
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         event_level_ff <= '0;
      else
         event_level_ff <= nxt_level;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         event_status_ff <= '0;
      else
         event_status_ff <= nxt_event_status;
   end

   // a control write restarts the foreground sequence
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         start_ff <= 1'b1;
      else
         start_ff <= wr_ctl;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         seq_ff <= SEQ_IDLE;
      else
         seq_ff <= nxt_seq;
   end

   // read data only in the access cycle, zero otherwise
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_ff <= 32'h0000_0000;
      else if (setup_phase)
         prdata_ff <= {24'h00_0000, read_byte};
      else
         prdata_ff <= 32'h0000_0000;
   end

   // one access cycle per transfer, no further wait states
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready_ff <= 1'b0;
      else
         pready_ff <= setup_phase;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pslverr_ff <= 1'b0;
      else
         pslverr_ff <= setup_phase && !hit_any;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         control_ff <= '0;
      else
         control_ff <= nxt_control;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status_pin_ff <= 1'b0;
      else
         status_pin_ff <= nxt_status_pin;
   end

   // irq follows the status update of the same edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_ff <= 1'b0;
      else
         irq_ff <= |(nxt_event_status & event_mask_ff);
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign engine_control = control_ff;
   assign status_output_pin = status_pin_ff;
   assign irq = irq_ff;
endmodule

// File: rtl/cal_regs_pkg.sv
// package of offsets, field positions, reset values and carriers for the calibration registers
package cal_regs_pkg;
   // printed offsets are register indices, byte address is four times the index
   localparam logic [7:0] IDX_OFFSET_REFERENCE_CONFIG = 8'h65;
   localparam logic [7:0] IDX_CALIBRATION_AVERAGING = 8'h68;
   localparam logic [7:0] IDX_CALIBRATION_PROGRESS = 8'h6A;
   localparam logic [7:0] IDX_CALIBRATION_PIN_SETUP = 8'h6B;
   localparam logic [7:0] IDX_CALIBRATION_CONTROL = 8'h70;
   localparam logic [7:0] IDX_EVENT_STATUS = 8'h71;
   localparam logic [7:0] IDX_EVENT_MASK = 8'h72;

   localparam logic [7:0] RST_OFFSET_REFERENCE_CONFIG = 8'h01;
   localparam logic [7:0] RST_CALIBRATION_AVERAGING = 8'h61;
   localparam logic [7:0] RST_CALIBRATION_PIN_SETUP = 8'h00;
   // foreground enable and software trigger bit both start high
   localparam logic [7:0] RST_CALIBRATION_CONTROL = 8'h05;
   localparam logic [2:0] RST_EVENT_MASK = 3'h0;

   localparam int OFFSET_REFERENCE_SELECT_BIT = 2;
   localparam int OFFSET_AVERAGE_DEPTH_LSB = 4;
   localparam int LINEARITY_AVERAGE_DEPTH_LSB = 0;
   localparam int AVERAGE_DEPTH_WIDTH = 3;
   localparam int STATUS_CODE_LSB = 2;
   localparam int BACKGROUND_HALTED_BIT = 1;
   localparam int FOREGROUND_COMPLETE_BIT = 0;
   localparam int STATUS_PIN_SELECT_LSB = 1;
   localparam int TRIGGER_SOURCE_SELECT_BIT = 0;
   localparam int FOREGROUND_ENABLE_BIT = 0;
   localparam int BACKGROUND_ENABLE_BIT = 1;
   localparam int SOFTWARE_TRIGGER_BIT = 2;

   localparam logic [1:0] PIN_SEL_FOREGROUND = 2'h0;
   localparam logic [1:0] PIN_SEL_BACKGROUND = 2'h1;
   localparam logic [1:0] PIN_SEL_ALARM = 2'h2;

   localparam int EVT_FOREGROUND = 0;
   localparam int EVT_BACKGROUND = 1;
   localparam int EVT_ALARM = 2;
   localparam int EVENT_COUNT = 3;

   // what the calibration engine reports back
   typedef struct packed {
      logic alarm;
      logic bg_running;
      logic bg_stopped;
      logic foreground_complete_flag;
      logic [2:0] code;
   } engine_report_t;

   // what this block hands to the calibration engine
   typedef struct packed {
      logic clear_values;
      logic fg_run;
      logic foreground_enable;
      logic background_enable;
      logic offset_reference_select;
      logic [2:0] offset_average_depth;
      logic [2:0] linearity_average_depth;
      logic cal_trigger;
   } engine_control_t;
endpackage

// File: testbench/cal_regs_props.sv
// concurrent checks on the calibration register bank ports
`timescale 1ns/1ps
module cal_regs_props
   import cal_regs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic trigger_input_pin,
   input wire cal_regs_pkg::engine_report_t engine_report,
   input wire cal_regs_pkg::engine_control_t engine_control,
   input wire logic status_output_pin,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic wr_hit = psel && penable && pready && pwrite && pstrb[0];
   rdy_pulse_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   rdy_single_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error without ready or with data");
   offset_reference_select_follow_a: assert property (wr_hit && paddr == 12'h194 |=> ##1
      engine_control.offset_reference_select == $past(pwdata[2], 2))
      else $error("reference select not applied");
   avg_follow_a: assert property (wr_hit && paddr == 12'h1A0 |=> ##1
      engine_control.offset_average_depth == $past(pwdata[6:4], 2) &&
      engine_control.linearity_average_depth == $past(pwdata[2:0], 2))
      else $error("averaging depth not applied");
   clear_once_a: assert property ($rose(engine_control.clear_values) |=>
      !engine_control.clear_values)
      else $error("clear pulse too long");
   fg_start_a: assert property (engine_control.clear_values &&
      engine_control.foreground_enable |=> engine_control.fg_run)
      else $error("foreground run missing");
   fg_stop_a: assert property (engine_control.fg_run && engine_report.foreground_complete_flag |=>
      !engine_control.fg_run)
      else $error("foreground run not ended");
   cover property (wr_hit && paddr == 12'h194);
   cover property (pslverr);
   cover property ($rose(irq));
endmodule
bind adc_calibration_config_status cal_regs_props i_props (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .trigger_input_pin,
   .engine_report, .engine_control, .status_output_pin, .irq);

// File: testbench/adc_calibration_config_status_bench.sv
// self-checking bench for the calibration register bank
`timescale 1ns/1ps
module adc_calibration_config_status_bench;
   import cal_regs_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tp = 0;
   logic pready, pslverr, pin, irq, e;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic [3:0] pstrb = 4'hF;
   engine_report_t er = '0;
   engine_control_t ec;
   int err_total = 0, checks = 0, cyc = 0;
   always #2.5 pclk = ~pclk;
   adc_calibration_config_status i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .trigger_input_pin(tp),
      .engine_report(er), .engine_control(ec), .status_output_pin(pin), .irq);
   task report_and_stop;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x)
      begin
         err_total++;
         $display("MISMATCH %0t got %h want %h", $time, g, x);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // holds the request until pready is seen high at an edge
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] x);
      apb(0, a, 8'h0);
      chk(r, x);
   endtask
   task pulse(input int b);
      @(posedge pclk);
      er[b] <= 1;
      @(posedge pclk);
      er[b] <= 0;
      tick(3);
   endtask
   task t_reset;
      rd(12'h194, 32'h01);
      rd(12'h1A0, 32'h61);
      rd(12'h1AC, 32'h00);
      rd(12'h1A8, 32'h00);
      apb(0, 12'h000, 8'h0);
      chk(e, 1);
      chk(r, 0);
   endtask
   task t_done;
      er.code <= 3'h5;
      pulse(3);
      rd(12'h1A8, 32'h17);
      apb(1, 12'h1A8, 8'hFF);
      rd(12'h1A8, 32'h17);
   endtask
   task t_irq;
      apb(1, 12'h1C8, 8'h03);
      tick(3);
      chk(irq, 1);
      rd(12'h1C4, 32'h03);
      tick(3);
      chk(irq, 0);
   endtask
   task t_pin;
      er.alarm <= 1;
      for (int i = 0; i < 4; i++)
      begin
         apb(1, 12'h1AC, 8'(i * 2));
         tick(3);
         chk(pin, 32'(i < 3));
      end
      er.alarm <= 0;
   endtask
   task t_trig;
      apb(1, 12'h1AC, 8'h01);
      tick(3);
      chk(ec.cal_trigger, 0);
      tp <= 1;
      tick(3);
      chk(ec.cal_trigger, 1);
      tp <= 0;
      apb(1, 12'h1AC, 8'h00);
      tick(3);
      chk(ec.cal_trigger, 1);
   endtask
   // select 1 only once background is enabled
   task t_bg;
      apb(1, 12'h1C0, 8'h07);
      tick(4);
      chk(ec.background_enable, 1);
      pulse(5);
      rd(12'h1A8, 32'h14);
      pulse(4);
      rd(12'h1A8, 32'h16);
      apb(1, 12'h194, 8'h05);
      tick(3);
      chk(ec.offset_reference_select, 1);
      apb(1, 12'h194, 8'h01);
      tick(3);
      chk(ec.offset_reference_select, 0);
      // background and foreground off: skip sets both flags
      pulse(5);
      apb(1, 12'h1C0, 8'h04);
      tick(4);
      rd(12'h1A8, 32'h17);
   endtask
   task t_avg;
      apb(1, 12'h1A0, 8'h75);
      tick(3);
      chk(ec.offset_average_depth, 7);
      chk(ec.linearity_average_depth, 5);
      rd(12'h1A0, 32'h75);
   endtask
   // mid-run reset restores registers and clears the flags
   task t_rerun;
      @(posedge pclk);
      presetn <= 0;
      tick(2);
      presetn <= 1;
      rd(12'h1A0, 32'h61);
      rd(12'h1A8, 32'h14);
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_total++;
         report_and_stop;
      end
   end
   initial
   begin
      tick(20);
      presetn <= 1;
      t_reset;
      t_done;
      t_irq;
      t_pin;
      t_trig;
      t_bg;
      t_avg;
      t_rerun;
      report_and_stop;
   end
endmodule
